// >>> dual_timer_ext_irq_control.sv
// Dual timer/counter with external interrupt detection behind an Avalon-MM slave
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dual_timer_defines.svh"

module dual_timer_ext_irq_control #(
  parameter int DIV_RATIO = `SLOW_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Pins
  input wire logic irq_a_pin_n,
  input wire logic irq_b_pin_n,
  input wire logic tmr_a_count_pin,
  input wire logic tmr_b_count_pin,
  // Status
  output logic tmr_a_overflow_flag,
  output logic tmr_b_overflow_flag,
  output logic irq_a_request_flag,
  output logic irq_b_request_flag
);
  import dual_timer_pkg::*;

  // The divider counter is four bits wide, so larger ratios cannot be served
  if (DIV_RATIO < 2 || DIV_RATIO > 16) begin : g_bad_ratio
    $error("DIV_RATIO must lie between 2 and 16");
  end

  state_t s_q;
  state_t s_d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // One counting step of a timer; returns {overflow, high, low}
  function automatic logic [16:0] step(input timer_mode_t m, input logic [7:0] hi, input logic [7:0] lo);
    logic [16:0] r;
    logic [5:0] l5;
    logic [8:0] h9;
    logic [16:0] w;
    logic [8:0] l9;
    r = {1'b0, hi, lo};
    l5 = {1'b0, lo[4:0]} + 6'h01;
    h9 = {1'b0, hi} + 9'h001;
    w = {1'b0, hi, lo} + 17'h00001;
    l9 = {1'b0, lo} + 9'h001;
    case (m)
      MODE_13BIT: begin
        // Low five bits carry into the full high byte; upper low bits left alone
        if (l5[5]) begin
          r = {h9[8], h9[7:0], lo[7:5], 5'h00};
        end else begin
          r = {1'b0, hi, lo[7:5], l5[4:0]};
        end
      end
      MODE_16BIT: begin
        r = w;
      end
      MODE_RELOAD8: begin
        if (l9[8]) begin
          r = {1'b1, hi, hi};
        end else begin
          r = {1'b0, hi, l9[7:0]};
        end
      end
      default: begin
        r = {l9[8], hi, l9[7:0]};
      end
    endcase
    return r;
  endfunction

  // Byte lane write of the low byte of a word
  function automatic logic [7:0] wr8(input logic [7:0] old, input logic en, input logic [7:0] v);
    return en ? v : old;
  endfunction

  logic [7:0] idx;
  logic bus_hit;
  logic wr_lane;
  assign idx = address[9:2];
  // Writes land at the edge that ends the answer cycle, when the master sees waitrequest low
  assign wr_lane = write && byteenable[0] && (s_q.bus == BUS_DONE);

  always_comb begin
    bus_hit = 1'b0;
    case (idx)
      `REG_CTRL_IDX, `REG_MODE_IDX, `REG_A_LOW_IDX, `REG_B_LOW_IDX, `REG_A_HIGH_IDX, `REG_B_HIGH_IDX,
      `REG_CLK_IDX, `REG_VECTOR_IDX: begin
        bus_hit = 1'b1;
      end
      default: begin
        bus_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic slow_tick;
    logic a_fall_irq;
    logic b_fall_irq;
    logic a_fall_cnt;
    logic b_fall_cnt;
    logic a_tick;
    logic b_tick;
    logic a_en;
    logic b_en;
    logic ah_en;
    logic [16:0] a_res;
    logic [16:0] b_res;
    logic [8:0] ah9;
    logic a_ovf;
    logic b_ovf;
    logic [3:0] ack;
    timer_mode_t a_mode;
    timer_mode_t b_mode;
    logic [3:0] a_cfg;
    logic [3:0] b_cfg;
    logic [7:0] wv;
    s_d = s_q;
    wv = writedata[7:0];
    ack = 4'h0;
    a_cfg = s_q.mode[3:0];
    b_cfg = s_q.mode[7:4];
    a_mode = timer_mode_t'(a_cfg[1:0]);
    b_mode = timer_mode_t'(b_cfg[1:0]);

    // Pins are asynchronous: three stages, change accepted when stages two and three agree
    s_d.sync_a_irq = {s_q.sync_a_irq[1:0], irq_a_pin_n};
    s_d.sync_b_irq = {s_q.sync_b_irq[1:0], irq_b_pin_n};
    s_d.sync_a_cnt = {s_q.sync_a_cnt[1:0], tmr_a_count_pin};
    s_d.sync_b_cnt = {s_q.sync_b_cnt[1:0], tmr_b_count_pin};
    if (s_q.sync_a_irq[1] == s_q.sync_a_irq[2]) begin
      s_d.a_irq_lvl = s_q.sync_a_irq[2];
    end
    if (s_q.sync_b_irq[1] == s_q.sync_b_irq[2]) begin
      s_d.b_irq_lvl = s_q.sync_b_irq[2];
    end
    if (s_q.sync_a_cnt[1] == s_q.sync_a_cnt[2]) begin
      s_d.a_cnt_lvl = s_q.sync_a_cnt[2];
    end
    if (s_q.sync_b_cnt[1] == s_q.sync_b_cnt[2]) begin
      s_d.b_cnt_lvl = s_q.sync_b_cnt[2];
    end
    a_fall_irq = s_q.a_irq_lvl && !s_d.a_irq_lvl;
    b_fall_irq = s_q.b_irq_lvl && !s_d.b_irq_lvl;
    a_fall_cnt = s_q.a_cnt_lvl && !s_d.a_cnt_lvl;
    b_fall_cnt = s_q.b_cnt_lvl && !s_d.b_cnt_lvl;

    // Divide-by-DIV_RATIO enable shared by both timers
    slow_tick = (s_q.div == 4'(DIV_RATIO - 1));
    s_d.div = slow_tick ? 4'h0 : s_q.div + 4'h1;

    // Timer clock: external edges bypass the rate select
    a_tick = a_cfg[`MODE_SRC] ? a_fall_cnt
           : (s_q.clk_rate[`CLK_A_RATE] ? 1'b1 : slow_tick);
    b_tick = b_cfg[`MODE_SRC] ? b_fall_cnt
           : (s_q.clk_rate[`CLK_B_RATE] ? 1'b1 : slow_tick);
    a_en = a_tick && s_q.ctrl[`CTRL_A_RUN] && (!a_cfg[`MODE_GATE] || s_q.a_irq_lvl);
    b_en = b_tick && s_q.ctrl[`CTRL_B_RUN] && (!b_cfg[`MODE_GATE] || s_q.b_irq_lvl)
         && (b_mode != MODE_SPLIT);
    // Split high half always runs from the internal clock
    ah_en = (a_mode == MODE_SPLIT) && s_q.ctrl[`CTRL_B_RUN]
          && (s_q.clk_rate[`CLK_A_RATE] ? 1'b1 : slow_tick);

    a_res = step(a_mode, s_q.a_high, s_q.a_low);
    b_res = step(b_mode, s_q.b_high, s_q.b_low);
    ah9 = {1'b0, s_q.a_high} + 9'h001;
    a_ovf = a_en && a_res[16];
    b_ovf = (b_en && b_res[16]) || (ah_en && ah9[8]);
    if (a_en) begin
      s_d.a_low = a_res[7:0];
      if (a_mode != MODE_SPLIT) begin
        s_d.a_high = a_res[15:8];
      end
    end
    if (ah_en) begin
      s_d.a_high = ah9[7:0];
    end
    if (b_en) begin
      s_d.b_low = b_res[7:0];
      s_d.b_high = b_res[15:8];
    end

    // Bus slave: one wait cycle, then answer
    s_d.bus = BUS_IDLE;
    if ((read || write) && s_q.bus == BUS_IDLE) begin
      s_d.bus = BUS_DONE;
      s_d.rdata = 32'h00000000;
      case (idx)
        `REG_CTRL_IDX: s_d.rdata = {24'h000000, s_q.ctrl};
        `REG_MODE_IDX: s_d.rdata = {24'h000000, s_q.mode};
        `REG_A_LOW_IDX: s_d.rdata = {24'h000000, s_q.a_low};
        `REG_B_LOW_IDX: s_d.rdata = {24'h000000, s_q.b_low};
        `REG_A_HIGH_IDX: s_d.rdata = {24'h000000, s_q.a_high};
        `REG_B_HIGH_IDX: s_d.rdata = {24'h000000, s_q.b_high};
        `REG_CLK_IDX: s_d.rdata = {24'h000000, 3'h0, s_q.clk_rate[4:3], 3'h0};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    if (wr_lane && bus_hit) begin
      case (idx)
        `REG_CTRL_IDX: s_d.ctrl = wv;
        `REG_MODE_IDX: s_d.mode = wv;
        `REG_A_LOW_IDX: s_d.a_low = wv;
        `REG_B_LOW_IDX: s_d.b_low = wv;
        `REG_A_HIGH_IDX: s_d.a_high = wv;
        `REG_B_HIGH_IDX: s_d.b_high = wv;
        `REG_CLK_IDX: s_d.clk_rate = wr8(s_q.clk_rate, 1'b1, wv & 8'h18);
        `REG_VECTOR_IDX: ack = wv[3:0];
        default: ack = 4'h0;
      endcase
    end

    // Vector entry clears; a hardware set in the same cycle wins
    if (ack[`VEC_A_OVF]) begin
      s_d.ctrl[`CTRL_A_OVF] = 1'b0;
    end
    if (ack[`VEC_B_OVF]) begin
      s_d.ctrl[`CTRL_B_OVF] = 1'b0;
    end
    if (ack[`VEC_A_IRQ]) begin
      s_d.ctrl[`CTRL_A_IRQ] = 1'b0;
    end
    if (ack[`VEC_B_IRQ]) begin
      s_d.ctrl[`CTRL_B_IRQ] = 1'b0;
    end
    if (a_ovf) begin
      s_d.ctrl[`CTRL_A_OVF] = 1'b1;
    end
    if (b_ovf) begin
      s_d.ctrl[`CTRL_B_OVF] = 1'b1;
    end
    // Request flags: level mode tracks the pin and ignores software
    if (!s_d.ctrl[`CTRL_A_TRIG]) begin
      s_d.ctrl[`CTRL_A_IRQ] = !s_d.a_irq_lvl;
    end else if (a_fall_irq) begin
      s_d.ctrl[`CTRL_A_IRQ] = 1'b1;
    end
    if (!s_d.ctrl[`CTRL_B_TRIG]) begin
      s_d.ctrl[`CTRL_B_IRQ] = !s_d.b_irq_lvl;
    end else if (b_fall_irq) begin
      s_d.ctrl[`CTRL_B_IRQ] = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.ctrl <= `CTRL_RESET;
      s_q.mode <= `MODE_RESET;
      s_q.clk_rate <= `CLK_RESET;
      // Pins idle high so no false edge after release
      s_q.sync_a_irq <= 3'h7;
      s_q.sync_b_irq <= 3'h7;
      s_q.sync_a_cnt <= 3'h7;
      s_q.sync_b_cnt <= 3'h7;
      s_q.a_irq_lvl <= 1'b1;
      s_q.b_irq_lvl <= 1'b1;
      s_q.a_cnt_lvl <= 1'b1;
      s_q.b_cnt_lvl <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign waitrequest = (read || write) && (s_q.bus == BUS_IDLE);
  assign readdata = s_q.rdata;
  assign tmr_a_overflow_flag = s_q.ctrl[`CTRL_A_OVF];
  assign tmr_b_overflow_flag = s_q.ctrl[`CTRL_B_OVF];
  assign irq_a_request_flag = s_q.ctrl[`CTRL_A_IRQ];
  assign irq_b_request_flag = s_q.ctrl[`CTRL_B_IRQ];

endmodule

// >>> dual_timer_defines.svh
// Offsets, field positions, reset values and timing counts of the dual timer block
`ifndef DUAL_TIMER_DEFINES_SVH
`define DUAL_TIMER_DEFINES_SVH

// ----------------------------------------
// Register word offsets (byte address = 4 x index)
// ----------------------------------------
`define REG_CTRL_IDX 8'h88
`define REG_MODE_IDX 8'h89
`define REG_A_LOW_IDX 8'h8a
`define REG_B_LOW_IDX 8'h8b
`define REG_A_HIGH_IDX 8'h8c
`define REG_B_HIGH_IDX 8'h8d
`define REG_CLK_IDX 8'h8e
`define REG_VECTOR_IDX 8'h90

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_B_OVF 7
`define CTRL_B_RUN 6
`define CTRL_A_OVF 5
`define CTRL_A_RUN 4
`define CTRL_B_IRQ 3
`define CTRL_B_TRIG 2
`define CTRL_A_IRQ 1
`define CTRL_A_TRIG 0

// ----------------------------------------
// Mode register fields (per nibble: gate, source, mode[1:0])
// ----------------------------------------
`define MODE_GATE 3
`define MODE_SRC 2
`define MODE_HI 1
`define MODE_LO 0

// ----------------------------------------
// Clock rate register fields
// ----------------------------------------
`define CLK_B_RATE 4
`define CLK_A_RATE 3

// ----------------------------------------
// Vector acknowledge bits
// ----------------------------------------
`define VEC_A_OVF 0
`define VEC_B_OVF 1
`define VEC_A_IRQ 2
`define VEC_B_IRQ 3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define CLK_RESET 8'h00
`define SLOW_DIV 12

`endif

// >>> dual_timer_pkg.sv
// Types shared by the dual timer block
package dual_timer_pkg;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } timer_mode_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_DONE
  } bus_state_t;

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] clk_rate;
    logic [7:0] a_low;
    logic [7:0] a_high;
    logic [7:0] b_low;
    logic [7:0] b_high;
    logic [3:0] div;
    logic [2:0] sync_a_irq;
    logic [2:0] sync_b_irq;
    logic [2:0] sync_a_cnt;
    logic [2:0] sync_b_cnt;
    logic a_irq_lvl;
    logic b_irq_lvl;
    logic a_cnt_lvl;
    logic b_cnt_lvl;
  } state_t;

endpackage

// >>> dual_timer_partner.sv
// Pin-side model: interrupt and count pins driven on command
`timescale 1ns/1ps
module dual_timer_partner (
  // Clock
  input wire logic clk,
  // Pins
  output logic irq_a_pin_n,
  output logic irq_b_pin_n,
  output logic tmr_a_count_pin,
  output logic tmr_b_count_pin
);
  // ----
  // Pins idle high
  // ----
  initial begin
    irq_a_pin_n = 1'b1;
    irq_b_pin_n = 1'b1;
    tmr_a_count_pin = 1'b1;
    tmr_b_count_pin = 1'b1;
  end
  // Each level is held long enough for the three-flop synchroniser
  task set_irq(input int sel, input logic v);
    @(posedge clk);
    if (sel == 0) irq_a_pin_n <= v; else irq_b_pin_n <= v;
    repeat (8) @(posedge clk);
  endtask
  task pulses(input int sel, input int n);
    repeat (n) begin
      @(posedge clk);
      if (sel == 0) tmr_a_count_pin <= 1'b0; else tmr_b_count_pin <= 1'b0;
      repeat (4) @(posedge clk);
      if (sel == 0) tmr_a_count_pin <= 1'b1; else tmr_b_count_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// >>> dual_timer_sva.sv
// Bus handshake and flag cause assertions for the dual timer block
`timescale 1ns/1ps
module dual_timer_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Pins and flags
  input wire logic irq_a_pin_n,
  input wire logic irq_b_pin_n,
  input wire logic tmr_a_overflow_flag,
  input wire logic tmr_b_overflow_flag,
  input wire logic irq_a_request_flag,
  input wire logic irq_b_request_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----
  // Bus
  // ----
  sequence s_new_req;
    (read || write) && !$past(read || write);
  endsequence
  sequence s_one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  a_bus_one_wait: assert property (s_new_req |-> s_one_wait) else $error("bus answer not after one wait");
  a_rd_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0) else $error("upper bits set");
  a_unmapped_zero: assert property (read && !waitrequest && address[9:2] >= 8'h90 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  // ----
  // Request flags only move for a pin or a write, overflow flags only fall for a write; the sync delay is at least three clocks
  // ----
  a_irq_a_rise: assert property ($rose(irq_a_request_flag) && !$past(write) && !$past(write, 2) |->
    !$past(irq_a_pin_n, 3)) else $error("irq a flag rose without pin");
  a_irq_b_rise: assert property ($rose(irq_b_request_flag) && !$past(write) && !$past(write, 2) |->
    !$past(irq_b_pin_n, 3)) else $error("irq b flag rose without pin");
  a_irq_a_fall: assert property ($fell(irq_a_request_flag) |->
    $past(write) || $past(write, 2) || $past(irq_a_pin_n, 3)) else $error("irq a flag fell alone");
  a_irq_b_fall: assert property ($fell(irq_b_request_flag) |->
    $past(write) || $past(write, 2) || $past(irq_b_pin_n, 3)) else $error("irq b flag fell alone");
  a_ovf_a_fall: assert property ($fell(tmr_a_overflow_flag) |-> $past(write) || $past(write, 2))
    else $error("a overflow fell alone");
  a_ovf_b_fall: assert property ($fell(tmr_b_overflow_flag) |-> $past(write) || $past(write, 2))
    else $error("b overflow fell alone");
endmodule
bind dual_timer_ext_irq_control dual_timer_sva u_dual_timer_sva (.clk(clk), .reset_n(reset_n), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .irq_a_pin_n(irq_a_pin_n),
  .irq_b_pin_n(irq_b_pin_n), .tmr_a_overflow_flag(tmr_a_overflow_flag), .tmr_b_overflow_flag(tmr_b_overflow_flag),
  .irq_a_request_flag(irq_a_request_flag), .irq_b_request_flag(irq_b_request_flag));

// >>> dual_timer_ext_irq_control_tb_top.sv
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module dual_timer_ext_irq_control_tb_top;
  import dual_timer_pkg::*;
  logic clk = 1'b0;
  logic reset_n;
  logic [9:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  wire logic ia_n, ib_n, ca, cb;
  logic [1:0] ovf;
  logic [1:0] irqf;
  int miscompares = 0;
  int n_tests = 0;
  // Rows: mode, a high, a low, b high, b low, control, expected {b, a} overflow
  logic [55:0] rows [9] = '{56'h00ff1e00001001, 56'h01fffe00001001, 56'h02feff00001001, 56'h03ff0000004002,
    56'h300000ffff4000, 56'h100000fffe4002, 56'h200000feff4002, 56'h000000ff1e4002, 56'h01ffffffff0000};
  logic [7:0] rst_idx [4] = '{8'h88, 8'h89, 8'h8e, 8'h91};
  always #10 clk = ~clk;
  dual_timer_ext_irq_control #(.DIV_RATIO(4)) u_dual_timer_ext_irq_control (.clk(clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq_a_pin_n(ia_n), .irq_b_pin_n(ib_n),
    .tmr_a_count_pin(ca), .tmr_b_count_pin(cb), .tmr_a_overflow_flag(ovf[0]), .tmr_b_overflow_flag(ovf[1]),
    .irq_a_request_flag(irqf[0]), .irq_b_request_flag(irqf[1]));
  dual_timer_partner u_dual_timer_partner (.clk(clk), .irq_a_pin_n(ia_n), .irq_b_pin_n(ib_n),
    .tmr_a_count_pin(ca), .tmr_b_count_pin(cb));
  // ----
  // Bus master; writes end with two spare edges so registered flags settle before a check
  // ----
  task bus_wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    address <= {i, 2'b00};
    writedata <= {24'h0, d};
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task bus_rd(input logic [7:0] i, output logic [7:0] d);
    @(posedge clk);
    address <= {i, 2'b00};
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata[7:0];
    read <= 1'b0;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      bus_rd(rst_idx[i], v);
      `CHK("reset_or_unmapped", 8'h00, v)
    end
    bus_wr(8'h89, 8'h5a);
    bus_rd(8'h89, v);
    `CHK("mode_rw", 8'h5a, v)
    byteenable <= 4'h0;
    bus_wr(8'h89, 8'ha5);
    byteenable <= 4'h1;
    bus_rd(8'h89, v);
    `CHK("lane_refused", 8'h5a, v)
    bus_wr(8'h89, 8'h00);
  endtask
  task t_flags;
    bus_wr(8'h88, 8'ha0);
    `CHK("sw_set_ovf", 2'b11, ovf)
    bus_wr(8'h90, 8'h01);
    `CHK("vec_a", 2'b10, ovf)
    bus_wr(8'h90, 8'h02);
    `CHK("vec_b", 2'b00, ovf)
    bus_wr(8'h88, 8'ha0);
    bus_wr(8'h88, 8'h00);
    `CHK("sw_clr_ovf", 2'b00, ovf)
  endtask
  task t_irq;
    for (int s = 0; s < 2; s++) begin
      bus_wr(8'h88, s ? 8'h04 : 8'h01);
      u_dual_timer_partner.set_irq(s, 1'b0);
      u_dual_timer_partner.set_irq(s, 1'b1);
      `CHK("edge_latch", 1'b1, irqf[s])
      bus_wr(8'h90, s ? 8'h08 : 8'h04);
      `CHK("vec_clear", 1'b0, irqf[s])
      bus_wr(8'h88, s ? 8'h0c : 8'h03);
      `CHK("sw_set", 1'b1, irqf[s])
      bus_wr(8'h88, s ? 8'h08 : 8'h02);
      `CHK("level_ro", 1'b0, irqf[s])
      u_dual_timer_partner.set_irq(s, 1'b0);
      `CHK("level_low", 1'b1, irqf[s])
      u_dual_timer_partner.set_irq(s, 1'b1);
      `CHK("level_high", 1'b0, irqf[s])
    end
  endtask
  task t_ext;
    logic [7:0] v;
    for (int s = 0; s < 2; s++) begin
      bus_wr(8'h89, s ? 8'hd0 : 8'h0d);
      bus_wr(8'h8a + s[7:0], 8'h00);
      bus_wr(8'h88, s ? 8'h40 : 8'h10);
      u_dual_timer_partner.set_irq(s, 1'b0);
      u_dual_timer_partner.pulses(s, 3);
      u_dual_timer_partner.set_irq(s, 1'b1);
      u_dual_timer_partner.pulses(s, 4);
      bus_rd(8'h8a + s[7:0], v);
      `CHK("gated_count", 8'h04, v)
      bus_wr(8'h89, s ? 8'h50 : 8'h05);
      u_dual_timer_partner.set_irq(s, 1'b0);
      u_dual_timer_partner.pulses(s, 2);
      u_dual_timer_partner.set_irq(s, 1'b1);
      bus_rd(8'h8a + s[7:0], v);
      `CHK("ungated_count", 8'h06, v)
      bus_wr(8'h88, 8'h00);
    end
  endtask
  // Divider of 4 here; span of about 45 counted clocks per run
  task t_div;
    logic [7:0] v;
    logic [7:0] w;
    bus_wr(8'h89, 8'h11);
    for (int k = 0; k < 4; k++) begin
      bus_wr(8'h8e, k[1] ? (k[0] ? 8'h10 : 8'h08) : 8'h00);
      bus_wr(8'h8a + k[7:0] % 2, 8'h00);
      bus_wr(8'h88, k[0] ? 8'h40 : 8'h10);
      repeat (40) @(posedge clk);
      bus_wr(8'h88, 8'h00);
      bus_rd(8'h8a + k[7:0] % 2, v);
      `CHK("rate", 1'b1, k[1] ? (v >= 8'd40 && v <= 8'd50) : (v >= 8'd9 && v <= 8'd13))
      repeat (20) @(posedge clk);
      bus_rd(8'h8a + k[7:0] % 2, w);
      `CHK("hold", v, w)
    end
  endtask
  task t_modes;
    logic [55:0] r;
    bus_wr(8'h8e, 8'h18);
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      bus_wr(8'h88, 8'h00);
      bus_wr(8'h89, r[55:48]);
      bus_wr(8'h8c, r[47:40]);
      bus_wr(8'h8a, r[39:32]);
      bus_wr(8'h8d, r[31:24]);
      bus_wr(8'h8b, r[23:16]);
      bus_wr(8'h90, 8'h03);
      bus_wr(8'h88, r[15:8]);
      repeat (12) @(posedge clk);
      `CHK("ovf_flags", r[1:0], ovf)
    end
    bus_wr(8'h88, 8'h00);
  endtask
  initial begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h0;
    byteenable = 4'h1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_flags;
    t_irq;
    t_ext;
    t_div;
    t_modes;
    final_report;
  end
  // Whole run needs about 1300 clocks
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule
